// *** verilog/smc_pkg.sv ***
// package: register map, field positions, reset values and types
`default_nettype none
package smc_pkg;
  localparam logic [5:0] SMC_ADDR_COMMIT = 6'h00;
  localparam logic [5:0] SMC_ADDR_CP = 6'h09;
  localparam logic [5:0] SMC_ADDR_REF = 6'h0A;
  localparam logic [5:0] SMC_ADDR_PLL = 6'h0C;
  localparam logic [5:0] SMC_ADDR_LD2 = 6'h0D;
  localparam logic [5:0] SMC_ADDR_TXD = 6'h0E;
  localparam logic [5:0] SMC_ADDR_LD1 = 6'h17;
  localparam logic [5:0] SMC_ADDR_ACAL = 6'h18;
  localparam logic [5:0] SMC_ADDR_ATMR = 6'h19;
  localparam logic [5:0] SMC_ADDR_LOMON = 6'h1B;
  localparam logic [5:0] SMC_ADDR_LODIV = 6'h1C;
  localparam logic [5:0] SMC_ADDR_MOD = 6'h1D;
  localparam logic [5:0] SMC_ADDR_ATT = 6'h1E;
  localparam logic [5:0] SMC_ADDR_REV = 6'h21;
  // field positions
  localparam int SMC_CP_LSB = 4;
  localparam int SMC_REF_HALF_BIT = 6;
  localparam int SMC_REF_DBL_BIT = 5;
  localparam int SMC_PLL_PD_BIT = 2;
  localparam int SMC_LD2_CNT_BIT = 6;
  localparam int SMC_TXD_STOP_BIT = 7;
  localparam int SMC_LD1_EN_BIT = 4;
  localparam int SMC_LD1_CNT_BIT = 3;
  localparam int SMC_LD1_FINE_BIT = 2;
  localparam int SMC_ACAL_DIS_BIT = 0;
  localparam int SMC_LOMON_RANGE_BIT = 4;
  localparam int SMC_LOMON_PU_BIT = 2;
  localparam int SMC_LODIV_PD_BIT = 4;
  localparam int SMC_MOD_PU_BIT = 0;
  // reset value and attenuator code limits (all documented defaults are zero codes)
  localparam logic [7:0] SMC_RST_BYTE = 8'h00;
  localparam logic [5:0] SMC_ATT_HI_BASE = 6'h30;
  localparam logic [5:0] SMC_ATT_LO_MAX = 6'h1F;

  typedef struct packed {
    logic [3:0] cp_current;
    logic ref_half_sel;
    logic ref_doubler_en;
    logic [4:0] ref_div_code;
    logic [2:0] rf_division_select;
  } smc_shadow_t;

  typedef struct packed {
    logic pll_power_down;
    logic [1:0] lock_count;
    logic lock_det_en;
    logic lock_fine;
    logic autocal_en;
    logic [7:0] autocal_time;
    logic lo_range;
    logic lo_mon_power_up;
    logic [1:0] lo_mon_level;
    logic rf_output_divider_pd;
    logic mod_power_up;
    logic [5:0] atten_code;
    logic lo_run;
  } smc_direct_t;

  // direct fields under reset: calibration enabled, LO running
  localparam smc_direct_t SMC_DIRECT_RST = '{autocal_en: 1'b1, lo_run: 1'b1, default: '0};
endpackage
`default_nettype wire

// *** verilog/smc_byte_reg.sv ***
// file: one 8-bit writable register
`timescale 1ns/10ps
`default_nettype none
module smc_byte_reg
  import smc_pkg::*;
#(
  parameter logic [7:0] RESET_VALUE = 8'h00
)
(
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic load_in,
  input wire logic [7:0] data_in,
  output logic [7:0] value_out
);
  logic [7:0] value_reg;
  logic [7:0] value_next;
  always_comb
  begin
    value_next = value_reg;
    if (load_in)
    begin
      value_next = data_in;
    end
  end
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      value_reg <= RESET_VALUE;
    end
    else
    begin
      value_reg <= value_next;
    end
  end
  assign value_out = value_reg;
endmodule
`default_nettype wire

// *** verilog/smc_att_decode.sv ***
// file: attenuator code to decibel step
`timescale 1ns/10ps
`default_nettype none
module smc_att_decode
  import smc_pkg::*;
(
  input wire logic [5:0] code_in,
  output logic [5:0] db_out,
  output logic legal_out
);
  always_comb
  begin
    db_out = 6'h00;
    legal_out = 1'b1;
    if (code_in <= SMC_ATT_LO_MAX)
    begin
      db_out = code_in;
    end
    else if (code_in >= SMC_ATT_HI_BASE)
    begin
      db_out = code_in - SMC_ATT_HI_BASE + 6'h20;
    end
    else
    begin
      legal_out = 1'b0;
      db_out = SMC_ATT_LO_MAX;
    end
  end
endmodule
`default_nettype wire

// *** verilog/smc_regs.sv ***
// file: synthesizer and modulator control register bank
`timescale 1ns/10ps
`default_nettype none
module smc_regs
  import smc_pkg::*;
#(
  parameter logic [7:0] REVISION_CODE = 8'h5A // arbitrary value
)
(
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [5:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic transmit_disable_input_in,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  output smc_shadow_t active_out,
  output smc_direct_t direct_out,
  output logic [5:0] atten_db_out,
  output logic atten_legal_out,
  output logic pll_acquire_out
);
  // ----------------------------------------
  // write decode
  // ----------------------------------------
  function automatic logic hit(input logic [5:0] a, input logic [5:0] target);
    hit = (a == target);
  endfunction

  localparam int NREG = 12;
  localparam logic [5:0] ADDRS [NREG] = '{SMC_ADDR_CP, SMC_ADDR_REF, SMC_ADDR_PLL,
    SMC_ADDR_LD2, SMC_ADDR_TXD, SMC_ADDR_LD1, SMC_ADDR_ACAL, SMC_ADDR_ATMR,
    SMC_ADDR_LOMON, SMC_ADDR_LODIV, SMC_ADDR_MOD, SMC_ADDR_ATT};
  logic [7:0] reg_val [NREG];
  logic commit_wr;

  // revision address is not in the writable set, so writes drop
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++)
    begin : g_reg
      smc_byte_reg #(.RESET_VALUE(SMC_RST_BYTE)) u_reg (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .load_in(wr_en_in && hit(addr_in, ADDRS[gi])),
        .data_in(wr_data_in),
        .value_out(reg_val[gi])
      );
    end
  endgenerate

  assign commit_wr = wr_en_in && hit(addr_in, SMC_ADDR_COMMIT);

  // ----------------------------------------
  // shadow fields from staged bytes
  // ----------------------------------------
  smc_shadow_t staged;
  always_comb
  begin
    staged.cp_current = reg_val[0][SMC_CP_LSB +: 4];
    staged.ref_half_sel = reg_val[1][SMC_REF_HALF_BIT];
    staged.ref_doubler_en = reg_val[1][SMC_REF_DBL_BIT];
    staged.ref_div_code = reg_val[1][4:0];
    staged.rf_division_select = reg_val[9][2:0];
  end

  // ----------------------------------------
  // active (applied) stage and outputs
  // ----------------------------------------
  smc_shadow_t active_reg;
  smc_shadow_t active_next;
  smc_direct_t direct_reg;
  smc_direct_t direct_next;
  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;
  logic rd_valid_reg;
  logic rd_valid_next;
  logic acq_reg;
  logic acq_next;
  logic [5:0] att_db_reg;
  logic att_legal_reg;
  logic [5:0] att_db_w;
  logic att_legal_w;

  smc_att_decode u_att (
    .code_in(reg_val[11][5:0]),
    .db_out(att_db_w),
    .legal_out(att_legal_w)
  );

  always_comb
  begin
    active_next = active_reg;
    acq_next = 1'b0;
    if (commit_wr)
    begin
      active_next = staged;
      acq_next = 1'b1;
    end
    direct_next.pll_power_down = reg_val[2][SMC_PLL_PD_BIT];
    direct_next.lock_count = {reg_val[3][SMC_LD2_CNT_BIT], reg_val[5][SMC_LD1_CNT_BIT]};
    direct_next.lock_det_en = reg_val[5][SMC_LD1_EN_BIT];
    direct_next.lock_fine = reg_val[5][SMC_LD1_FINE_BIT];
    direct_next.autocal_en = ~reg_val[6][SMC_ACAL_DIS_BIT];
    direct_next.autocal_time = reg_val[7];
    direct_next.lo_range = reg_val[8][SMC_LOMON_RANGE_BIT];
    direct_next.lo_mon_power_up = reg_val[8][SMC_LOMON_PU_BIT];
    direct_next.lo_mon_level = reg_val[8][1:0];
    direct_next.rf_output_divider_pd = reg_val[9][SMC_LODIV_PD_BIT];
    direct_next.mod_power_up = reg_val[10][SMC_MOD_PU_BIT];
    direct_next.atten_code = reg_val[11][5:0];
    // lo runs unless stop enabled and transmit disabled
    direct_next.lo_run = ~(reg_val[4][SMC_TXD_STOP_BIT] & transmit_disable_input_in);
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  always_comb
  begin
    rd_data_next = 8'h00;
    rd_valid_next = rd_en_in;
    if (rd_en_in)
    begin
      if (hit(addr_in, SMC_ADDR_REV))
      begin
        rd_data_next = REVISION_CODE;
      end
      for (int i = 0; i < NREG; i++)
      begin
        if (hit(addr_in, ADDRS[i]))
        begin
          rd_data_next = reg_val[i];
        end
      end
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      active_reg <= '0;
      direct_reg <= SMC_DIRECT_RST;
      rd_data_reg <= 8'h00;
      rd_valid_reg <= 1'b0;
      acq_reg <= 1'b0;
      att_db_reg <= 6'h00;
      att_legal_reg <= 1'b1;
    end
    else
    begin
      active_reg <= active_next;
      direct_reg <= direct_next;
      rd_data_reg <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
      acq_reg <= acq_next;
      att_db_reg <= att_db_w;
      att_legal_reg <= att_legal_w;
    end
  end

  assign active_out = active_reg;
  assign direct_out = direct_reg;
  assign rd_data_out = rd_data_reg;
  assign rd_valid_out = rd_valid_reg;
  assign pll_acquire_out = acq_reg;
  assign atten_db_out = att_db_reg;
  assign atten_legal_out = att_legal_reg;
endmodule
`default_nettype wire

// *** bench/smc_regs_assertions.sv ***
// checker: bus, commit and decode properties of the register bank
`timescale 1ns/10ps
`default_nettype none
module smc_regs_assertions
  import smc_pkg::*;
#(
  parameter logic [7:0] REVISION_CODE = 8'h5A // arbitrary value
)
(
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [5:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic transmit_disable_input_in,
  input wire logic [7:0] rd_data_out,
  input wire logic rd_valid_out,
  input wire smc_shadow_t active_out,
  input wire smc_direct_t direct_out,
  input wire logic [5:0] atten_db_out,
  input wire logic atten_legal_out,
  input wire logic pll_acquire_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  // cycles since reset release, saturating
  logic [1:0] up_reg;
  logic [1:0] up_next;
  always_comb up_next = (up_reg == 2'h3) ? up_reg : up_reg + 2'h1;
  always_ff @(posedge core_clk_in) up_reg <= reset_in ? 2'h0 : up_next;
  sequence commit_s; wr_en_in && addr_in == SMC_ADDR_COMMIT; endsequence
  // a commit right behind another keeps the pulse high one more cycle
  sequence acq_pulse_s;
    pll_acquire_out ##1 (pll_acquire_out == $past(wr_en_in && addr_in == SMC_ADDR_COMMIT));
  endsequence
  AST_ACQ: assert property (commit_s |=> acq_pulse_s) else $error("no acquire pulse");
  AST_ACQ_CAUSE: assert property (
    $rose(pll_acquire_out) |-> $past(wr_en_in && addr_in == SMC_ADDR_COMMIT))
    else $error("acquire without commit");
  AST_SHADOW: assert property (
    !(wr_en_in && addr_in == SMC_ADDR_COMMIT) |=> $stable(active_out))
    else $error("applied field moved without commit");
  AST_MOD: assert property (
    wr_en_in && addr_in == SMC_ADDR_MOD |=> ##1 direct_out.mod_power_up == $past(wr_data_in[0], 2))
    else $error("modulator bit");
  AST_ATT: assert property (!atten_legal_out |-> atten_db_out == SMC_ATT_LO_MAX)
    else $error("illegal code step");
  AST_RD: assert property (rd_en_in |=> rd_valid_out) else $error("no read answer");
  AST_RD_IDLE: assert property (!rd_en_in |=> !rd_valid_out && rd_data_out == 8'h00)
    else $error("read data without read");
  AST_REV: assert property (
    rd_en_in && addr_in == SMC_ADDR_REV |=> rd_data_out == REVISION_CODE)
    else $error("revision value");
  AST_LO_RUN: assert property (
    up_reg == 2'h3 && !$past(transmit_disable_input_in) |-> direct_out.lo_run)
    else $error("lo stopped while enabled");
endmodule
bind smc_regs smc_regs_assertions #(.REVISION_CODE(REVISION_CODE)) i_smc_regs_assertions (
  .core_clk_in(core_clk_in), .reset_in(reset_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
  .addr_in(addr_in), .wr_data_in(wr_data_in), .rd_data_out(rd_data_out),
  .transmit_disable_input_in(transmit_disable_input_in), .rd_valid_out(rd_valid_out),
  .active_out(active_out), .direct_out(direct_out), .atten_db_out(atten_db_out),
  .atten_legal_out(atten_legal_out), .pll_acquire_out(pll_acquire_out));
`default_nettype wire

// *** bench/smc_host_model.sv ***
// host model: byte writes and reads on the register strobes
`timescale 1ns/10ps
`default_nettype none
module smc_host_model
(
  input wire logic core_clk_in,
  input wire logic [7:0] rd_data_in,
  output logic wr_en_out,
  output logic rd_en_out,
  output logic [5:0] addr_out,
  output logic [7:0] wr_data_out
);
  initial
  begin
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    addr_out = 6'h3F;
    wr_data_out = 8'h00;
  end
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge core_clk_in);
    addr_out = a;
    wr_data_out = d;
    wr_en_out = 1'b1;
    @(negedge core_clk_in);
    wr_en_out = 1'b0;
    // released bus shows no stale value
    addr_out = ~a;
    wr_data_out = ~d;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge core_clk_in);
    addr_out = a;
    rd_en_out = 1'b1;
    @(negedge core_clk_in);
    rd_en_out = 1'b0;
    addr_out = ~a;
    d = rd_data_in;
  endtask
endmodule
`default_nettype wire

// *** bench/smc_regs_test.sv ***
// testbench: register bank scenarios
`timescale 1ns/10ps
`default_nettype none
module smc_regs_test import smc_pkg::*;;
  localparam logic [7:0] REV = 8'h5A; // arbitrary value
  logic core_clk_in, reset_in, wr_en, rd_en, transmit_disable_input, rd_valid, legal, acq;
  logic [5:0] addr, att_db;
  logic [7:0] wr_data, rd_data, v;
  smc_shadow_t active;
  smc_direct_t direct, e;
  int n_errors = 0;
  int n_checks = 0;
  always #2 core_clk_in = ~core_clk_in;
  smc_regs #(.REVISION_CODE(REV)) i_smc_regs (.core_clk_in(core_clk_in), .reset_in(reset_in),
    .wr_en_in(wr_en), .rd_en_in(rd_en), .addr_in(addr), .wr_data_in(wr_data),
    .transmit_disable_input_in(transmit_disable_input), .rd_data_out(rd_data), .rd_valid_out(rd_valid),
    .active_out(active), .direct_out(direct), .atten_db_out(att_db),
    .atten_legal_out(legal), .pll_acquire_out(acq));
  smc_host_model i_host (.core_clk_in(core_clk_in), .rd_data_in(rd_data), .wr_en_out(wr_en),
    .rd_en_out(rd_en), .addr_out(addr), .wr_data_out(wr_data));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic settle();
    repeat (3) @(negedge core_clk_in);
  endtask
  task automatic print_verdict();
    if (n_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic t_defaults();
    e = '0;
    e.autocal_en = 1'b1;
    e.lo_run = 1'b1;
    chk(32'(direct), 32'(e));
    chk(32'(active), 32'h0);
  endtask
  task automatic t_shadow();
    i_host.wr(SMC_ADDR_CP, 8'hF0);
    i_host.wr(SMC_ADDR_REF, 8'h6A);
    i_host.wr(SMC_ADDR_LODIV, 8'h0D);
    settle();
    chk(32'(active), 32'h0);
    i_host.wr(SMC_ADDR_COMMIT, 8'h00);
    chk(32'(acq), 32'h1);
    chk(32'(active), 32'({4'hF, 1'b1, 1'b1, 5'h0A, 3'h5}));
  endtask
  task automatic t_direct();
    i_host.wr(SMC_ADDR_PLL, 8'h1C);
    i_host.wr(SMC_ADDR_LD2, 8'hE8);
    i_host.wr(SMC_ADDR_LD1, 8'h74);
    i_host.wr(SMC_ADDR_ACAL, 8'h19);
    i_host.wr(SMC_ADDR_ATMR, 8'hA5);
    i_host.wr(SMC_ADDR_LOMON, 8'h17);
    i_host.wr(SMC_ADDR_LODIV, 8'h18);
    i_host.wr(SMC_ADDR_MOD, 8'h81);
    i_host.wr(SMC_ADDR_ATT, 8'h3F);
    i_host.wr(SMC_ADDR_TXD, 8'h80);
    settle();
    e = '{1'b1, 2'b10, 1'b1, 1'b1, 1'b0, 8'hA5, 1'b1, 1'b1, 2'h3, 1'b1, 1'b1, 6'h3F, 1'b1};
    chk(32'(direct), 32'(e));
    chk(32'(active), 32'({4'hF, 1'b1, 1'b1, 5'h0A, 3'h5}));
    chk(32'(att_db), 32'h2F);
    transmit_disable_input = 1'b1;
    settle();
    chk(32'(direct.lo_run), 32'h0);
    i_host.wr(SMC_ADDR_TXD, 8'h00);
    settle();
    chk(32'(direct.lo_run), 32'h1);
    transmit_disable_input = 1'b0;
    i_host.rd(SMC_ADDR_ATMR, v);
    chk(32'(v), 32'hA5);
  endtask
  task automatic t_att();
    logic [5:0] c [4] = '{6'h1F, 6'h30, 6'h25, 6'h00};
    logic [5:0] d [4] = '{6'h1F, 6'h20, 6'h1F, 6'h00};
    logic l [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
    for (int i = 0; i < 4; i++)
    begin
      i_host.wr(SMC_ADDR_ATT, {2'b00, c[i]});
      settle();
      chk(32'(att_db), 32'(d[i]));
      chk(32'(legal), 32'(l[i]));
    end
  endtask
  task automatic t_rev();
    i_host.rd(SMC_ADDR_REV, v);
    chk(32'(v), 32'(REV));
    chk(32'(rd_valid), 32'h1);
    i_host.wr(SMC_ADDR_REV, 8'h00);
    i_host.rd(SMC_ADDR_REV, v);
    chk(32'(v), 32'(REV));
    i_host.rd(6'h20, v);
    chk(32'(v), 32'h0);
  endtask
  task automatic t_reset();
    reset_in = 1'b1;
    repeat (2) @(negedge core_clk_in);
    e = '0;
    e.autocal_en = 1'b1;
    e.lo_run = 1'b1;
    chk(32'(direct), 32'(e));
    chk(32'(active), 32'h0);
    chk(32'(att_db), 32'h0);
    reset_in = 1'b0;
    settle();
    chk(32'(direct), 32'(e));
    i_host.rd(SMC_ADDR_ATMR, v);
    chk(32'(v), 32'h0);
  endtask
  initial
  begin
    core_clk_in = 1'b0;
    reset_in = 1'b1;
    transmit_disable_input = 1'b0;
    repeat (10) @(negedge core_clk_in);
    reset_in = 1'b0;
    settle();
    t_defaults();
    t_shadow();
    t_direct();
    t_att();
    t_rev();
    t_reset();
    print_verdict();
  end
  // hang guard
  initial
  begin
    #40000;
    n_errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
